// ---- hw/irq_ctrl_consts.svh ----
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// Register byte offsets on the APB bus
`define OFS_PEND       12'h000
`define OFS_MASK       12'h004
`define OFS_CLEAR      12'h008
`define OFS_SHAPE      12'h00c
`define OFS_FORCE      12'h010
`define OFS_STATUS     12'h014

// Interrupt levels of the fifteen sources
`define NUM_LEVELS     15
`define LVL_NONE       4'h0
`define LVL_HW_ERR     4'h1
`define LVL_EXT0       4'h2
`define LVL_EXT1       4'h3
`define LVL_UARTA      4'h4
`define LVL_UARTB      4'h5
`define LVL_CORR       4'h6
`define LVL_UART_ERR   4'h7
`define LVL_DMA_ERR    4'h8
`define LVL_DMA_TO     4'h9
`define LVL_EXT2       4'ha
`define LVL_EXT3       4'hb
`define LVL_GPT        4'hc
`define LVL_RTC        4'hd
`define LVL_EXT4       4'he
`define LVL_WDOG       4'hf

// Trap types taken on acknowledge
`define TRAP_FIRST     8'h11
`define TRAP_LAST      8'h1f
`define TRAP_LVL_BASE  8'h10

// Shape register fields
`define NUM_EXT        5
`define SHP_POL_LSB    0
`define SHP_EDGE_LSB   5
`define SHP_SEL_LSB    10
`define SHP_SEL_W      3
`define SHP_EN_BIT     13
`define SHP_W          14
`define SHP_RST        14'h0000

// Reset values and the status register ext field position
`define MASK_RST       14'h3fff
`define PEND_RST       15'h0000
`define STAT_EXT_LSB   8

`endif

// ---- hw/irq_ctrl_pkg.sv ----
package irq_ctrl_pkg;
    typedef logic [3:0]  level_t;
    typedef logic [15:1] irq_vec_t;
    typedef logic [2:0]  ext_sel_t;
endpackage : irq_ctrl_pkg

// ---- hw/ext_irq_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_irq_filter (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic line_i,
    input  wire logic active_high_i,
    output logic      set_o,
    output logic      level_o
);
    logic meta_reg;
    logic sync_reg;
    logic ok1_reg;
    logic ok2_reg;
    logic act_d_reg;
    logic filt_d_reg;
    logic act;

    // Pin is asynchronous to the system clock
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            ok1_reg  <= 1'b0;
            ok2_reg  <= 1'b0;
        end else begin
            meta_reg <= line_i;
            sync_reg <= meta_reg;
            ok1_reg  <= 1'b1;
            ok2_reg  <= ok1_reg;
        end
    end

    // Reset zeros are no pin level; active low would see a false event
    assign act = ok2_reg & (sync_reg == active_high_i);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            act_d_reg  <= 1'b0;
            filt_d_reg <= 1'b0;
        end else begin
            act_d_reg  <= act;
            filt_d_reg <= level_o;
        end
    end

    // Two consecutive active cycles before anything is seen
    assign level_o = act & act_d_reg;
    assign set_o   = level_o & ~filt_d_reg;

    chk_filter_two: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ($past(active_high_i, 4) == active_high_i) && level_o
        |-> ($past(line_i, 2) == active_high_i)
         && ($past(line_i, 3) == active_high_i))
        else $error("External input seen before two active cycles");

    chk_edge_once: assert property (
        @(posedge clk_i) disable iff (reset_i)
        set_o |-> !$past(level_o) && level_o ##1 !set_o)
        else $error("Edge event without transition or longer than a cycle");
endmodule : ext_irq_filter
`default_nettype wire

// ---- hw/irq_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module irq_ctrl #(
    parameter int HW_ERR_W = 8
) (
    input  wire logic                CLK_SYS_I,
    input  wire logic                RESET_I,
    input  wire logic                PSEL_I,
    input  wire logic                PENABLE_I,
    input  wire logic                PWRITE_I,
    input  wire logic [11:0]         PADDR_I,
    input  wire logic [31:0]         PWDATA_I,
    output logic      [31:0]         PRDATA_O,
    output logic                     PREADY_O,
    output logic                     PSLVERR_O,
    input  wire logic                WDOG_TIMEOUT_I,
    input  wire logic                RTC_TICK_I,
    input  wire logic                GPT_TICK_I,
    input  wire logic                DMA_TIMEOUT_I,
    input  wire logic                DMA_ACCESS_ERR_I,
    input  wire logic                UART_ERR_I,
    input  wire logic                UARTA_RX_DONE_I,
    input  wire logic                UARTA_TX_DONE_I,
    input  wire logic                UARTB_RX_DONE_I,
    input  wire logic                UARTB_TX_DONE_I,
    input  wire logic                CORR_ERR_I,
    input  wire logic [HW_ERR_W-1:0] HW_ERR_I,
    input  wire logic [HW_ERR_W-1:0] HW_ERR_MASK_I,
    input  wire logic [4:0]          EXT_IRQ_I,
    input  wire logic                INTACK_I,
    input  wire logic [7:0]          TRAP_TYPE_I,
    output logic      [3:0]          REQUEST_LEVEL_OUT_O,
    output logic                     EXT_IRQ_ACK_PULSE_O,
    output logic                     ERROR_HALT_REQ_O
);
    irq_ctrl_pkg::irq_vec_t pend_reg;
    irq_ctrl_pkg::irq_vec_t pend_next;
    logic [14:1]            mask_reg;
    logic [`SHP_W-1:0]      shape_reg;
    irq_ctrl_pkg::level_t   req_reg;
    irq_ctrl_pkg::level_t   req_next;
    logic [31:0]            prdata_reg;
    logic                   ack_pulse_reg;
    logic                   halt_reg;
    logic                   hw_d_reg;

    function automatic irq_ctrl_pkg::level_t prio_level(
        input irq_ctrl_pkg::irq_vec_t v);
        irq_ctrl_pkg::level_t l;
        l = `LVL_NONE;
        for (int i = 1; i <= `NUM_LEVELS; i++) begin
            if (v[i]) begin
                l = 4'(i);
            end
        end
        return l;
    endfunction : prio_level

    function automatic irq_ctrl_pkg::irq_vec_t lvl_onehot(
        input irq_ctrl_pkg::level_t l);
        irq_ctrl_pkg::irq_vec_t v;
        for (int i = 1; i <= `NUM_LEVELS; i++) begin
            v[i] = (l == 4'(i));
        end
        return v;
    endfunction : lvl_onehot

    // Ext input index to its fixed level
    function automatic irq_ctrl_pkg::irq_vec_t ext_spread(
        input logic [4:0] e);
        irq_ctrl_pkg::irq_vec_t v;
        v = `PEND_RST;
        v[`LVL_EXT0] = e[0];
        v[`LVL_EXT1] = e[1];
        v[`LVL_EXT2] = e[2];
        v[`LVL_EXT3] = e[3];
        v[`LVL_EXT4] = e[4];
        return v;
    endfunction : ext_spread

    function automatic irq_ctrl_pkg::level_t ext_level(
        input irq_ctrl_pkg::ext_sel_t s);
        irq_ctrl_pkg::level_t l;
        unique case (s)
            3'h0:    l = `LVL_EXT0;
            3'h1:    l = `LVL_EXT1;
            3'h2:    l = `LVL_EXT2;
            3'h3:    l = `LVL_EXT3;
            3'h4:    l = `LVL_EXT4;
            default: l = `LVL_NONE;
        endcase
        return l;
    endfunction : ext_level

    // APB decode, zero wait states
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic hit_pend;
    logic hit_mask;
    logic hit_clear;
    logic hit_shape;
    logic hit_force;
    logic hit_status;
    logic addr_ok;
    logic [31:0] rd_mux;

    assign setup_ph   = PSEL_I & ~PENABLE_I;
    assign access_ph  = PSEL_I & PENABLE_I;
    assign wr_en      = access_ph & PWRITE_I;
    assign hit_pend   = (PADDR_I == `OFS_PEND);
    assign hit_mask   = (PADDR_I == `OFS_MASK);
    assign hit_clear  = (PADDR_I == `OFS_CLEAR);
    assign hit_shape  = (PADDR_I == `OFS_SHAPE);
    assign hit_force  = (PADDR_I == `OFS_FORCE);
    assign hit_status = (PADDR_I == `OFS_STATUS);
    assign addr_ok    = hit_pend | hit_mask | hit_clear | hit_shape
                      | hit_force | hit_status;
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = access_ph & ~addr_ok;

    // Shape register fields
    logic [4:0]             pol_high;
    logic [4:0]             edge_mode;
    irq_ctrl_pkg::ext_sel_t ack_sel;
    logic                   ack_en;

    assign pol_high  = shape_reg[`SHP_POL_LSB +: `NUM_EXT];
    assign edge_mode = shape_reg[`SHP_EDGE_LSB +: `NUM_EXT];
    assign ack_sel   = shape_reg[`SHP_SEL_LSB +: `SHP_SEL_W];
    assign ack_en    = shape_reg[`SHP_EN_BIT];

    // External inputs
    logic [4:0] ext_set;
    logic [4:0] ext_act;

    generate
        for (genvar g = 0; g < `NUM_EXT; g++) begin : g_ext
            ext_irq_filter u_filt (
                .clk_i         (CLK_SYS_I),
                .reset_i       (RESET_I),
                .line_i        (EXT_IRQ_I[g]),
                .active_high_i (pol_high[g]),
                .set_o         (ext_set[g]),
                .level_o       (ext_act[g])
            );
        end
    endgenerate

    // Internal sources at their fixed levels
    irq_ctrl_pkg::irq_vec_t int_set;
    logic                   hw_masked_any;
    logic                   hw_rise;

    assign hw_masked_any = |(HW_ERR_I & HW_ERR_MASK_I);
    // Error bits stay set, so only the rise raises level 1
    assign hw_rise = hw_masked_any & ~hw_d_reg;

    assign int_set[`LVL_WDOG]     = WDOG_TIMEOUT_I;
    assign int_set[`LVL_EXT4]     = 1'b0;
    assign int_set[`LVL_RTC]      = RTC_TICK_I;
    assign int_set[`LVL_GPT]      = GPT_TICK_I;
    assign int_set[`LVL_EXT3]     = 1'b0;
    assign int_set[`LVL_EXT2]     = 1'b0;
    assign int_set[`LVL_DMA_TO]   = DMA_TIMEOUT_I;
    assign int_set[`LVL_DMA_ERR]  = DMA_ACCESS_ERR_I;
    assign int_set[`LVL_UART_ERR] = UART_ERR_I;
    assign int_set[`LVL_CORR]     = CORR_ERR_I;
    assign int_set[`LVL_UARTB]    = UARTB_RX_DONE_I
                                  | UARTB_TX_DONE_I;
    assign int_set[`LVL_UARTA]    = UARTA_RX_DONE_I
                                  | UARTA_TX_DONE_I;
    assign int_set[`LVL_EXT1]     = 1'b0;
    assign int_set[`LVL_EXT0]     = 1'b0;
    assign int_set[`LVL_HW_ERR]   = hw_rise;

    // Acknowledge decode
    logic [7:0]             trap_ofs;
    logic                   ack_valid;
    irq_ctrl_pkg::level_t   ack_lvl;

    assign trap_ofs  = TRAP_TYPE_I - `TRAP_LVL_BASE;
    assign ack_valid = INTACK_I && (TRAP_TYPE_I >= `TRAP_FIRST)
                    && (TRAP_TYPE_I <= `TRAP_LAST);
    assign ack_lvl   = trap_ofs[3:0];

    // Pending update; a set always wins over a clear
    irq_ctrl_pkg::irq_vec_t src_set;
    irq_ctrl_pkg::irq_vec_t sw_clr;
    irq_ctrl_pkg::irq_vec_t ack_clr;
    irq_ctrl_pkg::irq_vec_t force_vec;
    irq_ctrl_pkg::irq_vec_t lvl_mask;
    irq_ctrl_pkg::irq_vec_t edge_part;
    irq_ctrl_pkg::irq_vec_t mask_vec;

    assign src_set   = int_set | ext_spread(ext_set);
    assign sw_clr    = (wr_en & hit_clear) ? PWDATA_I[15:1]
                                           : `PEND_RST;
    assign ack_clr   = ack_valid ? lvl_onehot(ack_lvl)
                                 : `PEND_RST;
    assign force_vec = (wr_en & hit_force) ? PWDATA_I[15:1] : `PEND_RST;
    assign lvl_mask  = ext_spread(~edge_mode);
    assign edge_part = (pend_reg & ~(sw_clr | ack_clr))
                     | src_set | force_vec;
    assign pend_next = (edge_part & ~lvl_mask)
                     | ((ext_spread(ext_act) | force_vec)
                        & lvl_mask);
    // Watchdog bit has no mask flop at all
    assign mask_vec  = {1'b0, mask_reg};
    // Recomputed each cycle, so a higher level displaces a lower one
    assign req_next  = prio_level(pend_next & ~mask_vec);

    assign rd_mux = hit_pend   ? {16'h0000, pend_reg, 1'b0} :
                    hit_mask   ? {16'h0000, 1'b0, mask_reg, 1'b0} :
                    hit_shape  ? {18'h00000, shape_reg} :
                    hit_status ? {19'h00000, ext_act, 4'h0, req_reg} :
                    32'h0000_0000;

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            pend_reg <= `PEND_RST;
            req_reg  <= `LVL_NONE;
        end else begin
            pend_reg <= pend_next;
            req_reg  <= req_next;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            mask_reg  <= `MASK_RST;
            shape_reg <= `SHP_RST;
        end else begin
            if (wr_en & hit_mask) begin
                mask_reg <= PWDATA_I[14:1];
            end
            if (wr_en & hit_shape) begin
                shape_reg <= PWDATA_I[`SHP_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RESET_I) begin
            prdata_reg    <= 32'h0000_0000;
            ack_pulse_reg <= 1'b0;
            halt_reg      <= 1'b0;
            hw_d_reg      <= 1'b0;
        end else begin
            if (setup_ph) begin
                prdata_reg <= rd_mux;
            end
            ack_pulse_reg <= ack_valid & ack_en
                           & (ack_lvl == ext_level(ack_sel));
            halt_reg <= |(HW_ERR_I & ~HW_ERR_MASK_I);
            hw_d_reg <= hw_masked_any;
        end
    end

    assign PRDATA_O            = prdata_reg;
    assign REQUEST_LEVEL_OUT_O = req_reg;
    assign EXT_IRQ_ACK_PULSE_O = ack_pulse_reg;
    assign ERROR_HALT_REQ_O    = halt_reg;

    default clocking cb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (RESET_I);

    chk_wdog_never_masked: assert property (
        WDOG_TIMEOUT_I |=> pend_reg[`LVL_WDOG]
                       ##0 (REQUEST_LEVEL_OUT_O == `LVL_WDOG))
        else $error("Watchdog event did not reach level 15");

    chk_highest_level: assert property (
        REQUEST_LEVEL_OUT_O
            == prio_level(pend_reg & ~{1'b0, $past(mask_reg)}))
        else $error("Presented level is not highest unmasked pending");

    chk_idle_zero: assert property (
        (pend_reg & ~mask_vec) == `PEND_RST && $stable(mask_reg)
        |-> REQUEST_LEVEL_OUT_O == `LVL_NONE)
        else $error("Request level not zero with nothing pending");

    chk_ack_clears: assert property (
        ack_valid && !(src_set[ack_lvl] | force_vec[ack_lvl]
                       | lvl_mask[ack_lvl])
        |=> !pend_reg[$past(ack_lvl)])
        else $error("Acknowledged pending bit not cleared");

    chk_sw_clear: assert property (
        wr_en && hit_clear
        |=> (pend_reg & $past(sw_clr)
             & ~$past(src_set | force_vec | lvl_mask)) == `PEND_RST)
        else $error("Clear register write left a bit pending");

    chk_level_follow: assert property (
        !edge_mode[0] && !(wr_en && hit_force)
        |=> pend_reg[`LVL_EXT0] == $past(ext_act[0]))
        else $error("Level mode pending does not follow the line");

    chk_ack_pulse: assert property (
        ack_valid && ack_en && ack_lvl == ext_level(ack_sel)
        |=> EXT_IRQ_ACK_PULSE_O ##1 !EXT_IRQ_ACK_PULSE_O
            || $past(ack_valid))
        else $error("External acknowledge pulse missing");

    chk_hw_level1: assert property (
        $rose(hw_masked_any) |=> pend_reg[`LVL_HW_ERR])
        else $error("Masked hardware error did not raise level 1");

    chk_reset_zero: assert property (
        disable iff (1'b0)
        RESET_I |=> REQUEST_LEVEL_OUT_O == `LVL_NONE
                    && pend_reg == `PEND_RST)
        else $error("Reset did not clear pending and request level");

    cov_wdog_req: cover property (
        REQUEST_LEVEL_OUT_O == `LVL_WDOG);
    cov_replace: cover property (
        REQUEST_LEVEL_OUT_O != `LVL_NONE
        ##1 REQUEST_LEVEL_OUT_O > $past(REQUEST_LEVEL_OUT_O));
    cov_ack_pulse: cover property (EXT_IRQ_ACK_PULSE_O);
    cov_level_mode: cover property (
        !edge_mode[1] && pend_reg[`LVL_EXT1] ##1 !pend_reg[`LVL_EXT1]);
endmodule : irq_ctrl
`default_nettype wire

// ---- bench/proc_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module proc_core_model (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [3:0] level_i,
    input  wire logic       ack_req_i,
    input  wire logic       slow_i,
    output var  logic       intack_o,
    output var  logic [7:0] trap_o
);
    logic       armed    = 1'b0;
    logic [2:0] wait_cnt = 3'h0;
    initial intack_o = 1'b0;
    initial trap_o   = 8'h5a;
    // Trap lines carry junk outside the acknowledge cycle
    always @(posedge clk_i) begin
        intack_o <= 1'b0;
        trap_o   <= ~trap_o;
        if (reset_i) begin
            armed <= 1'b0;
        end else if (ack_req_i && !armed) begin
            armed    <= 1'b1;
            wait_cnt <= slow_i ? 3'h4 : 3'h0;
        end else if (armed && wait_cnt != 3'h0) begin
            wait_cnt <= wait_cnt - 3'h1;
        end else if (armed && level_i != 4'h0) begin
            // Takes the level presented when it finally acks
            armed    <= 1'b0;
            intack_o <= 1'b1;
            trap_o   <= {4'h1, level_i};
        end
    end
endmodule : proc_core_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
module tb_top;
    typedef struct packed {logic [31:0] d; logic e;} rd_note_s;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0]          paddr = 12'h000;
    logic [31:0]          pwdata = 32'h0, prdata, rng = 32'h20eb;
    logic                 pready, pslverr, intack, ack_pulse, halt;
    logic [10:0]          ev = 11'h000;
    logic [7:0]           hw_err = 8'h00, hw_mask = 8'h00, trap;
    logic [4:0]           ext = 5'h1f;
    logic                 ack_req = 1'b0, slow = 1'b0;
    irq_ctrl_pkg::level_t lvl;
    rd_note_s             rd_q[$];
    rd_note_s             note;
    int                   fail_count = 0, checks_done = 0;
    irq_ctrl_pkg::level_t lvls [11] = '{`LVL_WDOG, `LVL_RTC, `LVL_GPT,
        `LVL_DMA_TO, `LVL_DMA_ERR, `LVL_UART_ERR, `LVL_UARTA, `LVL_UARTA,
        `LVL_UARTB, `LVL_UARTB, `LVL_CORR};
    irq_ctrl_pkg::level_t xl [5] = '{`LVL_EXT0, `LVL_EXT1, `LVL_EXT2,
        `LVL_EXT3, `LVL_EXT4};

    always #12.5 clk = ~clk;

    irq_ctrl dut (.CLK_SYS_I(clk), .RESET_I(rst), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .WDOG_TIMEOUT_I(ev[0]), .RTC_TICK_I(ev[1]), .GPT_TICK_I(ev[2]),
        .DMA_TIMEOUT_I(ev[3]), .DMA_ACCESS_ERR_I(ev[4]), .UART_ERR_I(ev[5]),
        .UARTA_RX_DONE_I(ev[6]), .UARTA_TX_DONE_I(ev[7]),
        .UARTB_RX_DONE_I(ev[8]), .UARTB_TX_DONE_I(ev[9]),
        .CORR_ERR_I(ev[10]), .HW_ERR_I(hw_err), .HW_ERR_MASK_I(hw_mask),
        .EXT_IRQ_I(ext), .INTACK_I(intack), .TRAP_TYPE_I(trap),
        .REQUEST_LEVEL_OUT_O(lvl), .EXT_IRQ_ACK_PULSE_O(ack_pulse),
        .ERROR_HALT_REQ_O(halt));

    proc_core_model core (.clk_i(clk), .reset_i(rst), .level_i(lvl),
        .ack_req_i(ack_req), .slow_i(slow), .intack_o(intack),
        .trap_o(trap));

    function automatic logic [31:0] xorshift32(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift32

    task automatic cmp_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    task automatic cmp_lvl(input irq_ctrl_pkg::level_t e);
        checks_done++;
        if (lvl !== e) begin
            fail_count++;
            $display("ERROR level expected %h seen %h", e, lvl);
        end
    endtask : cmp_lvl

    task automatic cmp_flag(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_flag

    // Read data is judged here, at the edge that completes the access
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1 && !pwr && rd_q.size() > 0) begin
            note = rd_q.pop_front();
            cmp_word("prdata", note.d, prdata);
            cmp_flag("pslverr", note.e, pslverr);
        end
    end

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic err);
        rd_q.push_back('{e, err});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic pulse(input logic [10:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 11'h000;
        @(negedge clk);
    endtask : pulse

    task automatic wait_lvl(input irq_ctrl_pkg::level_t e);
        int n;
        for (n = 0; n < 12 && lvl !== e; n++) @(negedge clk);
        cmp_lvl(e);
    endtask : wait_lvl

    task automatic ack(input logic s, input irq_ctrl_pkg::level_t e,
                       input logic p);
        @(posedge clk);
        slow    <= s;
        ack_req <= 1'b1;
        @(posedge clk);
        ack_req <= 1'b0;
        while (intack !== 1'b1) @(posedge clk);
        @(negedge clk);
        cmp_lvl(e);
        cmp_flag("ack_pulse", p, ack_pulse);
    endtask : ack

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    initial begin
        #(25 * 20000);
        fail_count++;
        end_sim();
    end

    initial begin
        int                   i, j;
        logic [31:0]          f;
        logic [31:0]          g;
        irq_ctrl_pkg::level_t e;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp_lvl(`LVL_NONE);
        rd(`OFS_PEND, 32'h0, 1'b0);
        rd(`OFS_MASK, 32'h7ffe, 1'b0);
        rd(`OFS_SHAPE, 32'h0, 1'b0);
        rd(12'h018, 32'h0, 1'b1);
        // Masked source pends without a request
        pulse(11'h002);
        cmp_lvl(`LVL_NONE);
        pulse(11'h001);
        cmp_lvl(`LVL_WDOG);
        rd(`OFS_STATUS, 32'hf, 1'b0);
        rd(`OFS_PEND, 32'ha000, 1'b0);
        apb(1'b1, `OFS_CLEAR, 32'h8000);
        wait_lvl(`LVL_NONE);
        apb(1'b1, `OFS_MASK, 32'h0);
        wait_lvl(`LVL_RTC);
        apb(1'b1, `OFS_CLEAR, 32'h2000);
        for (i = 0; i < 11; i++) begin
            pulse(11'h001 << i);
            cmp_lvl(lvls[i]);
            if (i[0]) begin
                apb(1'b1, `OFS_CLEAR, 32'h1 << lvls[i]);
                wait_lvl(`LVL_NONE);
            end else begin
                ack(i[1], `LVL_NONE, 1'b0);
            end
        end
        pulse(11'h40c);
        cmp_lvl(`LVL_GPT);
        pulse(11'h002);
        cmp_lvl(`LVL_RTC);
        ack(1'b1, `LVL_GPT, 1'b0);
        ack(1'b0, `LVL_DMA_TO, 1'b0);
        ack(1'b1, `LVL_CORR, 1'b0);
        ack(1'b0, `LVL_NONE, 1'b0);
        for (i = 0; i < 4; i++) begin
            rng = xorshift32(rng);
            f = {16'h0, rng[15:1], 1'b0} | 32'h2;
            // Level-mode ext bits keep a forced one for a single cycle
            g = f;
            for (j = 0; j < 5; j++) g[xl[j]] = 1'b0;
            e = `LVL_NONE;
            for (j = 1; j < 16; j++) if (g[j]) e = j[3:0];
            apb(1'b1, `OFS_FORCE, f);
            wait_lvl(e);
            rd(`OFS_PEND, g, 1'b0);
            apb(1'b1, `OFS_CLEAR, 32'hfffe);
            wait_lvl(`LVL_NONE);
        end
        @(posedge clk);
        hw_mask <= 8'h01;
        hw_err  <= 8'h01;
        wait_lvl(`LVL_HW_ERR);
        cmp_flag("halt", 1'b0, halt);
        @(posedge clk);
        hw_err <= 8'h03;
        repeat (2) @(negedge clk);
        cmp_flag("halt", 1'b1, halt);
        @(posedge clk);
        hw_err <= 8'h00;
        apb(1'b1, `OFS_CLEAR, 32'h2);
        wait_lvl(`LVL_NONE);
        // Ext0 edge active high with ack pulse, others level active low
        apb(1'b1, `OFS_SHAPE, 32'h2021);
        @(posedge clk);
        ext <= 5'h1e;
        repeat (6) @(negedge clk);
        apb(1'b1, `OFS_CLEAR, 32'hfffe);
        wait_lvl(`LVL_NONE);
        @(posedge clk);
        ext <= 5'h1f;
        @(posedge clk);
        ext <= 5'h1e;
        repeat (8) @(negedge clk);
        cmp_lvl(`LVL_NONE);
        @(posedge clk);
        ext <= 5'h1f;
        wait_lvl(`LVL_EXT0);
        ack(1'b0, `LVL_NONE, 1'b1);
        repeat (4) @(negedge clk);
        cmp_lvl(`LVL_NONE);
        @(posedge clk);
        ext <= 5'h1e;
        for (i = 1; i < 5; i++) begin
            @(posedge clk);
            ext <= 5'h1e & ~(5'h01 << i);
            wait_lvl(xl[i]);
            @(posedge clk);
            ext <= 5'h1e;
            wait_lvl(`LVL_NONE);
        end
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
